// ### src/sli_map.vh
`ifndef SLI_MAP_VH
`define SLI_MAP_VH
// Tick and timing figures, in milliseconds unless noted
`define SLI_CLK_HZ          10000000
`define SLI_TICK_MS         1
`define SLI_TICK_CYC        ((`SLI_CLK_HZ / 1000) * `SLI_TICK_MS)
`define SLI_FLASH_RED_MS    100
`define SLI_FLASH_RED_CNT   10
`define SLI_SHUTDOWN_BUTTON_ON_MS      800
`define SLI_SHUTDOWN_BUTTON_PER_MS     1000
`define SLI_SHUTDOWN_BUTTON_WIN_S      40
`define SLI_SHUTDOWN_BUTTON_WIN_MS     (`SLI_SHUTDOWN_BUTTON_WIN_S * 1000)
`define SLI_BAT_ON_MS       100
`define SLI_BAT_HI_PER_MS   1000
`define SLI_BAT_LO_PER_MS   500
`define SLI_SRC_FLASH_MS    20
`define SLI_SRC_FLASH_CNT   5'h0A
`define SLI_SRC_SETTLE_MS   3600
`define SLI_CAB_ON_MS       100
`define SLI_CAB_PER_MS      500
`define SLI_CHECK_ON_MS     4'h9
`define SLI_FAST_HALF_MS    50
`define SLI_BTN_DEB_MS      5
`define SLI_HOST_RST_MS     7'h64
`endif

// ### src/sli_sync.v
`timescale 1ns/1ps
// Two-flop synchroniser for a bank of pin inputs
module sli_sync #(
  parameter W = 8
) (
  input  wire         clk,
  input  wire         rstn,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta <= {W{1'b0}};
      q    <= {W{1'b0}};
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// ### src/sli_top.v
`timescale 1ns/1ps
`include "sli_map.vh"
module sli_top (
  input  wire CLK,
  input  wire RSTN,
  input  wire SHUTDOWN_BUTTON_N,
  input  wire MEASURE_ACTIVE,
  input  wire ON_BATTERY,
  input  wire BAT_ABOVE_3V6,
  input  wire BAT_ABOVE_3V4,
  input  wire BAT_ABOVE_3V2,
  input  wire CABLE_PRESENT,
  input  wire SOURCE_CHANGED,
  input  wire BOOST_RUNNING,
  input  wire LOWPOWER_CHECK,
  input  wire CHARGING,
  input  wire BATTERY_FAULT,
  input  wire TEMP_ALARM,
  output reg  RED_STATUS_LED,
  output reg  GREEN_STATUS_LED,
  output reg  BOOST_LED,
  output reg  CHARGE_LED,
  output reg  CABLE_LED,
  output reg  SHUTDOWN_ACTIVE,
  output reg  HOST_RESTART
);
  localparam S_IDLE = 2'd0;
  localparam S_MEAS = 2'd1;
  localparam S_SHUTDOWN_BUTTON = 2'd2;

  wire [12:0] s;
  sli_sync #(.W(13)) u_sync (
    .clk  (CLK),
    .rstn (RSTN),
    .d    ({~SHUTDOWN_BUTTON_N, MEASURE_ACTIVE, ON_BATTERY, BAT_ABOVE_3V6,
            BAT_ABOVE_3V4, BAT_ABOVE_3V2, CABLE_PRESENT, SOURCE_CHANGED,
            BOOST_RUNNING, LOWPOWER_CHECK, CHARGING, BATTERY_FAULT,
            TEMP_ALARM}),
    .q    (s)
  );
  wire btn = s[12];
  wire meas = s[11];
  wire on_bat = s[10];
  wire b36 = s[9];
  wire b34 = s[8];
  wire b32 = s[7];
  wire cable = s[6];
  wire src_chg = s[5];
  wire boost = s[4];
  wire lp_chk = s[3];
  wire charge_led = s[2];
  wire fault = s[1];
  wire temp = s[0];

  // Millisecond tick
  reg [13:0] pre;
  reg        tick;
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pre  <= 14'h0000;
      tick <= 1'b0;
    end else begin
      tick <= (pre == `SLI_TICK_CYC - 1);
      if (pre == `SLI_TICK_CYC - 1)
        pre <= 14'h0000;
      else
        pre <= pre + 14'h0001;
    end
  end

  // Free-running ms counter for periodic patterns
  reg [9:0] ms_1000;
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN)
      ms_1000 <= 10'h000;
    else if (tick)
      ms_1000 <= (ms_1000 == `SLI_BAT_HI_PER_MS - 1) ? 10'h000
                                                      : ms_1000 + 10'h001;
  end
  wire [9:0] ms_500 = (ms_1000 >= 10'd500) ? ms_1000 - 10'd500 : ms_1000;

  // Button debounce, press edge
  reg [4:0] deb;
  reg       btn_st;
  reg       btn_prev;
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      deb      <= 5'h00;
      btn_st   <= 1'b0;
      btn_prev <= 1'b0;
    end else begin
      btn_prev <= btn_st;
      if (btn == btn_st)
        deb <= 5'h00;
      else if (tick) begin
        if (deb == `SLI_BTN_DEB_MS - 1) begin
          btn_st <= btn;
          deb    <= 5'h00;
        end else
          deb <= deb + 5'h01;
      end
    end
  end
  wire press = btn_st & ~btn_prev;

  // Red status sequencer
  reg [1:0]  state;
  reg [15:0] rt;
  reg [3:0]  rflash;
  reg        meas_done;
  reg        meas_prev;
  wire low_bat = on_bat & ~b32;
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state     <= S_IDLE;
      rt        <= 16'h0000;
      rflash    <= 4'h0;
      meas_done <= 1'b0;
      meas_prev <= 1'b0;
    end else begin
      meas_prev <= meas;
      if (meas & ~meas_prev)
        meas_done <= 1'b0;
      case (state)
        S_IDLE: begin
          if (press | low_bat | temp) begin
            state <= S_SHUTDOWN_BUTTON;
            rt    <= 16'h0000;
          end else if (meas & ~meas_done) begin
            state  <= S_MEAS;
            rt     <= 16'h0000;
            rflash <= 4'h0;
          end
        end
        S_MEAS: begin
          if (press | low_bat | temp) begin
            state <= S_SHUTDOWN_BUTTON;
            rt    <= 16'h0000;
          end else if (tick) begin
            if (rt == `SLI_FLASH_RED_MS - 1) begin
              rt <= 16'h0000;
              if (rflash == `SLI_FLASH_RED_CNT - 1) begin
                state     <= S_IDLE;
                meas_done <= 1'b1;
              end else
                rflash <= rflash + 4'h1;
            end else
              rt <= rt + 16'h0001;
          end
        end
        S_SHUTDOWN_BUTTON: begin
          if (tick) begin
            if (rt == `SLI_SHUTDOWN_BUTTON_WIN_MS - 1)
              state <= S_IDLE;
            else
              rt <= rt + 16'h0001;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
  reg  [9:0] sd_ms;
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN)
      sd_ms <= 10'h000;
    else if (state != S_SHUTDOWN_BUTTON)
      sd_ms <= 10'h000;
    else if (tick)
      sd_ms <= (sd_ms == `SLI_SHUTDOWN_BUTTON_PER_MS - 1) ? 10'h000 : sd_ms + 10'h001;
  end

  reg next_red;
  always @* begin
    next_red = 1'b0;
    if (state == S_SHUTDOWN_BUTTON)
      next_red = (sd_ms < `SLI_SHUTDOWN_BUTTON_ON_MS);
    else if (state == S_MEAS)
      next_red = (rt < `SLI_FLASH_RED_MS / 2);
    else if (on_bat & b34 & ~b36)
      next_red = (ms_1000 < `SLI_BAT_ON_MS);
    else if (on_bat & b32 & ~b34)
      next_red = (ms_500 < `SLI_BAT_ON_MS);
  end

  // Source change: settle, then ten fast green flashes
  reg [11:0] settle;
  reg        settling;
  reg [4:0]  gflash;
  reg [4:0]  gt;
  reg        src_prev;
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      settle   <= 12'h000;
      settling <= 1'b0;
      gflash   <= 5'h00;
      gt       <= 5'h00;
      src_prev <= 1'b0;
    end else begin
      src_prev <= src_chg;
      if (src_chg & ~src_prev) begin
        settling <= 1'b1;
        settle   <= 12'h000;
      end else if (settling & tick) begin
        if (settle == `SLI_SRC_SETTLE_MS - 1) begin
          settling <= 1'b0;
          gflash   <= `SLI_SRC_FLASH_CNT;
          gt       <= 5'h00;
        end else
          settle <= settle + 12'h001;
      end else if ((gflash != 5'h00) & tick) begin
        if (gt == `SLI_SRC_FLASH_MS - 1) begin
          gt     <= 5'h00;
          gflash <= gflash - 5'h01;
        end else
          gt <= gt + 5'h01;
      end
    end
  end

  // Low-power check pulse on boost LED
  reg [3:0] chk;
  reg       chk_prev;
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      chk      <= 4'h0;
      chk_prev <= 1'b0;
    end else begin
      chk_prev <= lp_chk;
      if (lp_chk & ~chk_prev)
        // One extra tick so tick phase never cuts the pulse short
        chk <= (`SLI_CHECK_ON_MS + 4'h1);
      else if (tick & (chk != 4'h0))
        chk <= chk - 4'h1;
    end
  end

  // Host restart pulse
  reg [6:0] hr;
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN)
      hr <= 7'h00;
    else if (press)
      hr <= `SLI_HOST_RST_MS;
    else if (tick & (hr != 7'h00))
      hr <= hr - 7'h01;
  end

  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      RED_STATUS_LED   <= 1'b0;
      GREEN_STATUS_LED <= 1'b0;
      BOOST_LED        <= 1'b0;
      CHARGE_LED       <= 1'b0;
      CABLE_LED        <= 1'b0;
      SHUTDOWN_ACTIVE  <= 1'b0;
      HOST_RESTART     <= 1'b0;
    end else begin
      RED_STATUS_LED <= next_red;
      if (gflash != 5'h00)
        GREEN_STATUS_LED <= (gt < `SLI_SRC_FLASH_MS / 2);
      else
        GREEN_STATUS_LED <= cable & (ms_500 < `SLI_CAB_ON_MS);
      BOOST_LED <= boost | (chk != 4'h0);
      if (fault)
        CHARGE_LED <= (ms_1000[6:0] < `SLI_FAST_HALF_MS);
      else
        CHARGE_LED <= charge_led;
      CABLE_LED       <= cable;
      SHUTDOWN_ACTIVE <= (state == S_SHUTDOWN_BUTTON);
      HOST_RESTART    <= (hr != 7'h00);
    end
  end
endmodule

// ### bench/sli_checker.sv
`timescale 1ns/1ps
module sli_checker (
  input wire CLK,
  input wire RSTN,
  input wire MEASURE_ACTIVE,
  input wire ON_BATTERY,
  input wire BAT_ABOVE_3V2,
  input wire CABLE_PRESENT,
  input wire BOOST_RUNNING,
  input wire CHARGING,
  input wire BATTERY_FAULT,
  input wire RED_STATUS_LED,
  input wire BOOST_LED,
  input wire CHARGE_LED,
  input wire CABLE_LED,
  input wire SHUTDOWN_ACTIVE,
  input wire HOST_RESTART
);
  reg seen_meas;
  // Measurement flashes may outlive the request, so dark is judged only
  // before any measurement was ever asked for
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN)
      seen_meas <= 1'b0;
    else if (MEASURE_ACTIVE)
      seen_meas <= 1'b1;
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);
  property p_cab;
    $stable(CABLE_PRESENT) [*5] |-> CABLE_LED == CABLE_PRESENT;
  endproperty
  property p_chg_on;
    (CHARGING && !BATTERY_FAULT) [*5] |-> CHARGE_LED;
  endproperty
  property p_chg_off;
    (!CHARGING && !BATTERY_FAULT) [*5] |-> !CHARGE_LED;
  endproperty
  property p_bst;
    BOOST_RUNNING [*5] |-> BOOST_LED;
  endproperty
  property p_dark;
    (!seen_meas && !ON_BATTERY && !SHUTDOWN_ACTIVE) [*5] |-> !RED_STATUS_LED;
  endproperty
  property p_shutdown_button_go;
    (ON_BATTERY && !BAT_ABOVE_3V2) [*5] |-> ##[0:3] SHUTDOWN_ACTIVE;
  endproperty
  property p_shutdown_button_red;
    $rose(SHUTDOWN_ACTIVE) |-> ##[0:2] RED_STATUS_LED [*8];
  endproperty
  property p_host_len;
    $rose(HOST_RESTART) |-> HOST_RESTART [*8];
  endproperty
  a_cab: assert property (p_cab) else $error("cable led wrong");
  a_chg_on: assert property (p_chg_on) else $error("charge dark");
  a_chg_off: assert property (p_chg_off) else $error("charge lit");
  a_bst: assert property (p_bst) else $error("boost led dark");
  a_dark: assert property (p_dark) else $error("red lit");
  a_shutdown_button_go: assert property (p_shutdown_button_go) else $error("no shutdown");
  a_shutdown_button_red: assert property (p_shutdown_button_red) else $error("red off");
  a_host_len: assert property (p_host_len) else $error("short pulse");
  cover property ($rose(SHUTDOWN_ACTIVE));
  cover property ($rose(BOOST_LED) && !BOOST_RUNNING);
  cover property ($fell(CABLE_LED));
endmodule
bind sli_top sli_checker CHK (.CLK(CLK), .RSTN(RSTN),
  .MEASURE_ACTIVE(MEASURE_ACTIVE), .ON_BATTERY(ON_BATTERY),
  .BAT_ABOVE_3V2(BAT_ABOVE_3V2), .CABLE_PRESENT(CABLE_PRESENT),
  .BOOST_RUNNING(BOOST_RUNNING), .CHARGING(CHARGING),
  .BATTERY_FAULT(BATTERY_FAULT), .RED_STATUS_LED(RED_STATUS_LED),
  .BOOST_LED(BOOST_LED), .CHARGE_LED(CHARGE_LED), .CABLE_LED(CABLE_LED),
  .SHUTDOWN_ACTIVE(SHUTDOWN_ACTIVE), .HOST_RESTART(HOST_RESTART));

// ### bench/sli_btn_model.sv
`timescale 1ns/1ps
// Push button on a pulled-up line: high unless held down
module sli_btn_model (
  input  wire press,
  output wire btn_n
);
  assign btn_n = press ? 1'b0 : 1'b1;
endmodule

// ### bench/tb_status_led_indicator.sv
`timescale 1ns/1ps
module tb_status_led_indicator;
  reg  clk = 1'b0;
  reg  rstn = 1'b0;
  reg  meas = 1'b0, on_bat = 1'b0, b36 = 1'b1, b34 = 1'b1, b32 = 1'b1;
  reg  cab = 1'b0, src = 1'b0, bst = 1'b0, chk = 1'b0, charge_led = 1'b0;
  reg  flt = 1'b0, temp = 1'b0, press = 1'b0;
  wire btn_n, red, green, boost, charge, cable, shutdown_button, host;
  int  miscompares = 0;
  int  checks_done = 0;
  always #50 clk = ~clk;
  sli_btn_model BTN (.press(press), .btn_n(btn_n));
  sli_top DUT (.CLK(clk), .RSTN(rstn), .SHUTDOWN_BUTTON_N(btn_n),
    .MEASURE_ACTIVE(meas), .ON_BATTERY(on_bat), .BAT_ABOVE_3V6(b36),
    .BAT_ABOVE_3V4(b34), .BAT_ABOVE_3V2(b32), .CABLE_PRESENT(cab),
    .SOURCE_CHANGED(src), .BOOST_RUNNING(bst), .LOWPOWER_CHECK(chk),
    .CHARGING(charge_led), .BATTERY_FAULT(flt), .TEMP_ALARM(temp),
    .RED_STATUS_LED(red), .GREEN_STATUS_LED(green), .BOOST_LED(boost),
    .CHARGE_LED(charge), .CABLE_LED(cable), .SHUTDOWN_ACTIVE(shutdown_button),
    .HOST_RESTART(host));
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic cmp(input string n, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s exp %b got %b", n, e, g);
    end
  endtask
  task finish_test;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task t_reset;
    rstn = 1'b0;
    w(16);
    cmp("red", 1'b0, red);
    cmp("shutdown_button", 1'b0, shutdown_button);
    cmp("host", 1'b0, host);
    rstn = 1'b1;
    w(4);
  endtask
  task t_quiet;
    w(10);
    cmp("red", 1'b0, red);
    cmp("charge", 1'b0, charge);
    cmp("boost", 1'b0, boost);
    cmp("cable", 1'b0, cable);
    cmp("green", 1'b0, green);
  endtask
  task t_levels;
    cab = 1'b1;
    w(5);
    cmp("cable", 1'b1, cable);
    cmp("green", 1'b1, green);
    cab = 1'b0;
    charge_led = 1'b1;
    w(5);
    cmp("cable", 1'b0, cable);
    cmp("green", 1'b0, green);
    cmp("charge", 1'b1, charge);
    charge_led = 1'b0;
    bst = 1'b1;
    w(5);
    cmp("charge", 1'b0, charge);
    cmp("boost", 1'b1, boost);
    bst = 1'b0;
    flt = 1'b1;
    w(5);
    cmp("boost", 1'b0, boost);
    cmp("charge", 1'b1, charge);
    flt = 1'b0;
  endtask
  // Check pulse spans 9 ms plus up to one 1 ms tick of phase
  task t_check;
    chk = 1'b1;
    w(10);
    chk = 1'b0;
    w(9990);
    cmp("boost", 1'b1, boost);
    w(80010);
    cmp("boost", 1'b1, boost);
    w(10010);
    cmp("boost", 1'b0, boost);
  endtask
  // Press outlasts the debounce plus one tick of phase
  task t_button;
    press = 1'b1;
    w(30);
    cmp("host", 1'b0, host);
    w(59970);
    cmp("host", 1'b1, host);
    cmp("shutdown_button", 1'b1, shutdown_button);
    cmp("red", 1'b1, red);
    press = 1'b0;
  endtask
  task t_lowbat;
    t_reset;
    on_bat = 1'b1;
    b36 = 1'b0;
    w(10);
    cmp("red", 1'b1, red);
    b34 = 1'b0;
    w(10);
    cmp("red", 1'b1, red);
    cmp("shutdown_button", 1'b0, shutdown_button);
    b32 = 1'b0;
    w(20);
    cmp("shutdown_button", 1'b1, shutdown_button);
    cmp("red", 1'b1, red);
    on_bat = 1'b0;
    t_reset;
    cmp("shutdown_button", 1'b0, shutdown_button);
  endtask
  initial begin
    t_reset;
    t_quiet;
    t_levels;
    fork
      t_check;
      t_button;
    join
    t_lowbat;
    finish_test;
  end
  initial begin
    #12000000;
    miscompares++;
    finish_test;
  end
endmodule
